// *** hdl/tsg_top.sv ***
// two-wire slave, reset, filters and alarm of the temperature sensor
`timescale 1ns/10ps
module tsg_top #(
    parameter int TIMEOUT_CYC = tsg_pkg::TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic              CLK_SYS_I,
    input  wire logic              SYS_RST_I,
    input  wire logic              RESET_N_I,
    // two-wire bus
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output logic                   SDA_O,
    output logic                   SDA_OE_O,
    // address straps
    input  wire logic              ADDR_STRAP_BIT0_I,
    input  wire logic              ADDR_STRAP_BIT1_I,
    input  wire logic              ADDR_STRAP_BIT2_I,
    // converter side
    input  wire tsg_pkg::tsg_conv_s CONV_I,
    output logic                   SHUTDOWN_O,
    // alarm pin
    output logic                   OVERTEMP_ALARM_OUT_O,
    output logic                   OVERTEMP_ALARM_OUT_OE_O
);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int FW = $clog2(tsg_pkg::SPIKE_CYC + 1);
    localparam int RW = $clog2(tsg_pkg::RST_CYC + 1);

    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("TIMEOUT_CYC must be at least 2");
    end

    function automatic logic [7:0] rd_byte(input logic [1:0] p,
                                           input logic       lo,
                                           input logic [8:0] t,
                                           input logic [7:0] c,
                                           input logic [8:0] h,
                                           input logic [8:0] o);
        logic [8:0] v;
        v = (p == tsg_pkg::PTR_TEMP)  ? t :
            (p == tsg_pkg::PTR_THYST) ? h : o;
        if (p == tsg_pkg::PTR_CFG)
            return c;
        return lo ? {v[0], 7'h00} : v[8:1];
    endfunction : rd_byte

    // reset pin must stay low a full minimum width
    logic [RW-1:0] rst_cnt_ff;
    logic          pin_rst_ff;
    logic          rst;
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I || RESET_N_I) begin
            rst_cnt_ff <= '0;
            pin_rst_ff <= 1'b0;
        end else if (rst_cnt_ff == RW'(tsg_pkg::RST_CYC - 1)) begin
            pin_rst_ff <= 1'b1;
        end else begin
            rst_cnt_ff <= rst_cnt_ff + 1'b1;
        end
    end
    assign rst = SYS_RST_I || pin_rst_ff;

    // sync then spike filter: scl, sda, straps
    logic [4:0]    raw;
    logic [4:0]    s1_ff;
    logic [4:0]    s2_ff;
    logic [4:0]    flt_ff;
    logic [FW-1:0] fcnt_ff [5];
    assign raw = {ADDR_STRAP_BIT2_I, ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT0_I,
                  SDA_I, SCL_I};
    always_ff @(posedge CLK_SYS_I) begin
        if (rst) begin
            s1_ff <= 5'h03;
            s2_ff <= 5'h03;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        for (int i = 0; i < 5; i++) begin
            if (rst) begin
                flt_ff[i]  <= (i < 2);
                fcnt_ff[i] <= '0;
            end else if (s2_ff[i] == flt_ff[i]) begin
                fcnt_ff[i] <= '0;
            end else if (fcnt_ff[i] == FW'(tsg_pkg::SPIKE_CYC - 1)) begin
                flt_ff[i]  <= s2_ff[i];
                fcnt_ff[i] <= '0;
            end else begin
                fcnt_ff[i] <= fcnt_ff[i] + 1'b1;
            end
        end
    end

    // edges of the filtered bus lines
    logic scl_d_ff;
    logic sda_d_ff;
    always_ff @(posedge CLK_SYS_I) begin
        if (rst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= flt_ff[0];
            sda_d_ff <= flt_ff[1];
        end
    end
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl_rise = flt_ff[0] && !scl_d_ff;
    assign scl_fall = !flt_ff[0] && scl_d_ff;
    assign start_c  = flt_ff[0] && scl_d_ff && sda_d_ff && !flt_ff[1];
    assign stop_c   = flt_ff[0] && scl_d_ff && !sda_d_ff && flt_ff[1];

    // stuck data line watchdog
    logic [TW-1:0] to_cnt_ff;
    logic          to_hit;
    always_ff @(posedge CLK_SYS_I) begin
        if (rst || flt_ff[1])
            to_cnt_ff <= '0;
        else if (!to_hit)
            to_cnt_ff <= to_cnt_ff + 1'b1;
    end
    assign to_hit = (to_cnt_ff == TW'(TIMEOUT_CYC));

    // registers
    logic [8:0] temp_ff;
    logic [7:0] cfg_ff;
    logic [8:0] thyst_ff;
    logic [8:0] tos_ff;
    logic [7:0] hold_ff;

    // bus engine
    tsg_pkg::tsg_state_e state_ff;
    logic [7:0] sh_ff;
    logic [3:0] cnt_ff;
    logic       rw_ff;
    logic       nack_ff;
    logic [1:0] ptr_ff;
    logic [1:0] idx_ff;
    logic       oe_ff;
    logic       rx_stb;
    logic       addr_ok;
    logic [7:0] nxt_byte;
    logic       reading;
    logic       rd_start;
    assign addr_ok  = sh_ff[7:1] == {tsg_pkg::ADDR_PREFIX, flt_ff[4:2]};
    assign rx_stb   = (state_ff == tsg_pkg::ST_RX) && scl_fall
                      && (cnt_ff == 4'h8);
    assign nxt_byte = rd_byte(ptr_ff, idx_ff[0], temp_ff, cfg_ff,
                              thyst_ff, tos_ff);
    assign reading  = rw_ff && (state_ff == tsg_pkg::ST_TX
                      || state_ff == tsg_pkg::ST_TXACK);
    assign rd_start = (state_ff == tsg_pkg::ST_AACK) && scl_fall && rw_ff;

    always_ff @(posedge CLK_SYS_I) begin
        if (rst) begin
            state_ff <= tsg_pkg::ST_IDLE;
            sh_ff    <= 8'h00;
            cnt_ff   <= 4'h0;
            rw_ff    <= 1'b0;
            nack_ff  <= 1'b0;
            ptr_ff   <= tsg_pkg::PTR_TEMP;
            idx_ff   <= 2'h0;
            oe_ff    <= 1'b0;
        end else if (to_hit) begin
            state_ff <= tsg_pkg::ST_IDLE;
            oe_ff    <= 1'b0;
        end else if (start_c) begin
            state_ff <= tsg_pkg::ST_ADDR;
            cnt_ff   <= 4'h0;
            idx_ff   <= 2'h0;
            oe_ff    <= 1'b0;
        end else if (stop_c) begin
            state_ff <= tsg_pkg::ST_IDLE;
            oe_ff    <= 1'b0;
        end else begin
            unique case (state_ff)
                tsg_pkg::ST_IDLE: ;
                tsg_pkg::ST_ADDR, tsg_pkg::ST_RX: begin
                    if (scl_rise && cnt_ff != 4'h8) begin
                        sh_ff  <= {sh_ff[6:0], flt_ff[1]};
                        cnt_ff <= cnt_ff + 1'b1;
                    end else if (scl_fall && cnt_ff == 4'h8) begin
                        oe_ff <= 1'b1;
                        if (state_ff == tsg_pkg::ST_RX) begin
                            state_ff <= tsg_pkg::ST_RXACK;
                            if (idx_ff == 2'h0)
                                ptr_ff <= sh_ff[1:0];
                        end else if (addr_ok) begin
                            state_ff <= tsg_pkg::ST_AACK;
                            rw_ff    <= sh_ff[0];
                        end else begin
                            state_ff <= tsg_pkg::ST_IDLE;
                            oe_ff    <= 1'b0;
                        end
                    end
                end
                tsg_pkg::ST_AACK, tsg_pkg::ST_TXACK: begin
                    if (scl_rise)
                        nack_ff <= flt_ff[1];
                    if (scl_fall) begin
                        cnt_ff <= 4'h0;
                        if (state_ff == tsg_pkg::ST_TXACK && nack_ff) begin
                            state_ff <= tsg_pkg::ST_IDLE;
                            oe_ff    <= 1'b0;
                        end else if (rw_ff) begin
                            sh_ff    <= nxt_byte;
                            oe_ff    <= !nxt_byte[7];
                            idx_ff   <= idx_ff + 1'b1;
                            state_ff <= tsg_pkg::ST_TX;
                        end else begin
                            oe_ff    <= 1'b0;
                            state_ff <= tsg_pkg::ST_RX;
                        end
                    end
                end
                tsg_pkg::ST_RXACK: begin
                    if (scl_fall) begin
                        oe_ff    <= 1'b0;
                        cnt_ff   <= 4'h0;
                        idx_ff   <= (idx_ff == 2'h3) ? 2'h2 : idx_ff + 1'b1;
                        state_ff <= tsg_pkg::ST_RX;
                    end
                end
                tsg_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_ff == 4'h7) begin
                            oe_ff    <= 1'b0;
                            state_ff <= tsg_pkg::ST_TXACK;
                        end else begin
                            sh_ff  <= {sh_ff[6:0], 1'b0};
                            oe_ff  <= !sh_ff[6];
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                    end
                end
                default: state_ff <= tsg_pkg::ST_IDLE;
            endcase
        end
    end

    // register writes; config top bits forced to zero
    always_ff @(posedge CLK_SYS_I) begin
        if (rst) begin
            cfg_ff   <= tsg_pkg::CFG_RST;
            thyst_ff <= tsg_pkg::THYST_RST;
            tos_ff   <= tsg_pkg::TOS_RST;
            hold_ff  <= 8'h00;
        end else if (rx_stb && idx_ff != 2'h0) begin
            if (ptr_ff == tsg_pkg::PTR_CFG && idx_ff == 2'h1)
                cfg_ff <= {3'h0, sh_ff[4:0]};
            else if (idx_ff[0])
                hold_ff <= sh_ff;
            else if (ptr_ff == tsg_pkg::PTR_THYST)
                thyst_ff <= {hold_ff, sh_ff[7]};
            else if (ptr_ff == tsg_pkg::PTR_TOS)
                tos_ff <= {hold_ff, sh_ff[7]};
        end
    end

    // a conversion landing mid-read is dropped, the next one counts
    always_ff @(posedge CLK_SYS_I) begin
        if (rst)
            temp_ff <= tsg_pkg::TEMP_RST;
        else if (CONV_I.done && !reading)
            temp_ff <= CONV_I.temp;
    end

    // fault queue and hysteresis
    logic [2:0] need;
    logic [2:0] fault_ff;
    logic       over_ff;
    logic       irq_ff;
    logic       beyond;
    always_comb begin
        unique case (cfg_ff[tsg_pkg::CFG_FQ_HI:tsg_pkg::CFG_FQ_LO])
            2'h0: need = tsg_pkg::FQ_N0;
            2'h1: need = tsg_pkg::FQ_N1;
            2'h2: need = tsg_pkg::FQ_N2;
            2'h3: need = tsg_pkg::FQ_N3;
        endcase
    end
    assign beyond = over_ff ? ($signed(CONV_I.temp) < $signed(thyst_ff))
                            : ($signed(CONV_I.temp) > $signed(tos_ff));
    always_ff @(posedge CLK_SYS_I) begin
        if (rst) begin
            fault_ff <= 3'h0;
            over_ff  <= 1'b0;
            irq_ff   <= 1'b0;
        end else begin
            if (CONV_I.done && !cfg_ff[tsg_pkg::CFG_SHDN]) begin
                if (!beyond) begin
                    fault_ff <= 3'h0;
                end else if (fault_ff + 1'b1 >= need) begin
                    fault_ff <= 3'h0;
                    over_ff  <= !over_ff;
                end else begin
                    fault_ff <= fault_ff + 1'b1;
                end
            end
            // new trip wins over a read that clears the same cycle
            if (CONV_I.done && !cfg_ff[tsg_pkg::CFG_SHDN] && beyond
                && fault_ff + 1'b1 >= need)
                irq_ff <= 1'b1;
            else if (rd_start)
                irq_ff <= 1'b0;
        end
    end

    // pins: bus and alarm low level constant, only the enable moves; shutdown driven as a level
    logic alarm;
    assign alarm = cfg_ff[tsg_pkg::CFG_INTR] ? irq_ff : over_ff;
    always_ff @(posedge CLK_SYS_I) begin
        if (rst) begin
            OVERTEMP_ALARM_OUT_O    <= 1'b0;
            OVERTEMP_ALARM_OUT_OE_O <= 1'b0;
            SDA_O                   <= 1'b0;
            SDA_OE_O                <= 1'b0;
            SHUTDOWN_O              <= 1'b0;
        end else begin
            OVERTEMP_ALARM_OUT_O    <= 1'b0;
            OVERTEMP_ALARM_OUT_OE_O <= alarm ^ cfg_ff[tsg_pkg::CFG_POL];
            SDA_O                   <= 1'b0;
            SDA_OE_O                <= oe_ff && !to_hit;
            SHUTDOWN_O              <= cfg_ff[tsg_pkg::CFG_SHDN];
        end
    end
endmodule : tsg_top

// *** pkg/tsg_pkg.sv ***
// shared constants and types of the temperature sensor bus slave
package tsg_pkg;
    // clock rate and time figures
    localparam int CLK_MHZ     = 250;
    localparam int SPIKE_NS    = 50;
    localparam int RST_MIN_US  = 1;
    localparam int TIMEOUT_MS  = 150;
    localparam int SPIKE_CYC   = (SPIKE_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_CYC     = RST_MIN_US * CLK_MHZ;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
    // bus address prefix
    localparam logic [3:0] ADDR_PREFIX = 4'h9;
    // register pointers
    localparam logic [1:0] PTR_TEMP  = 2'h0;
    localparam logic [1:0] PTR_CFG   = 2'h1;
    localparam logic [1:0] PTR_THYST = 2'h2;
    localparam logic [1:0] PTR_TOS   = 2'h3;
    // power-on values
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [8:0] THYST_RST = 9'h096;
    localparam logic [8:0] TOS_RST   = 9'h0A0;
    localparam logic [8:0] TEMP_RST  = 9'h000;
    // configuration field positions
    localparam int CFG_SHDN  = 0;
    localparam int CFG_INTR  = 1;
    localparam int CFG_POL   = 2;
    localparam int CFG_FQ_LO = 3;
    localparam int CFG_FQ_HI = 4;
    // fault queue depths per setting
    localparam logic [2:0] FQ_N0 = 3'h1;
    localparam logic [2:0] FQ_N1 = 3'h2;
    localparam logic [2:0] FQ_N2 = 3'h4;
    localparam logic [2:0] FQ_N3 = 3'h6;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_AACK  = 3'h3,
        ST_RX    = 3'h2,
        ST_RXACK = 3'h6,
        ST_TX    = 3'h7,
        ST_TXACK = 3'h5
    } tsg_state_e;

    // one finished conversion
    typedef struct packed {
        logic       done;
        logic [8:0] temp;
    } tsg_conv_s;
endpackage : tsg_pkg

// *** verification/tb_top.sv ***
// self-checking bench of the sensor bus slave
`timescale 1ns/10ps
module tb_top;
    localparam int TO = 3000;
    localparam int NF [4] = '{1, 2, 4, 6};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rst_n = 1'b1;
    logic gl = 1'b0;
    logic [2:0] strap;
    tsg_pkg::tsg_conv_s conv = '0;
    logic m_scl;
    logic m_sda;
    logic sda_oe;
    logic shdn;
    logic al_oe;
    logic rx_stb;
    logic [7:0] rx_val;
    logic [7:0] q[$];
    logic [8:0] t;
    logic [8:0] t2;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    // open-drain wires with pull-ups
    wire logic scl = !m_scl || gl;
    wire logic sda = !(m_sda || sda_oe);

    always #2 clk = !clk;

    tsg_top #(.TIMEOUT_CYC(TO)) i_tsg_top (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .RESET_N_I(rst_n),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe),
        .ADDR_STRAP_BIT0_I(strap[0]), .ADDR_STRAP_BIT1_I(strap[1]),
        .ADDR_STRAP_BIT2_I(strap[2]), .CONV_I(conv), .SHUTDOWN_O(shdn),
        .OVERTEMP_ALARM_OUT_O(), .OVERTEMP_ALARM_OUT_OE_O(al_oe));
    tsg_master #(.Q(20)) i_tsg_master (
        .clk_i(clk), .sda_i(sda), .scl_oe_o(m_scl), .sda_oe_o(m_sda),
        .rx_stb_o(rx_stb), .rx_val_o(rx_val));

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // each byte or acknowledge seen is held against the oldest note
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            n_errors++;
            end_sim();
        end
        if (rx_stb) check({1'b0, rx_val},
                          q.size() > 0 ? {1'b0, q.pop_front()} : 9'h1FF);
    end
    task automatic xw(input logic [7:0] d, input logic [7:0] e);
        q.push_back(e);
        i_tsg_master.wbyte(d);
    endtask : xw
    task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
        i_tsg_master.start();
        xw({tsg_pkg::ADDR_PREFIX, strap, 1'b0}, 8'h00);
        xw(p, 8'h00);
        for (int i = 0; i < n; i++) xw(d[15 - 8 * i -: 8], 8'h00);
        i_tsg_master.stop();
    endtask : wr
    task automatic rd(input logic [7:0] p, input int n, input logic [15:0] e);
        wr(p, 0, 16'h0000);
        i_tsg_master.start();
        xw({tsg_pkg::ADDR_PREFIX, strap, 1'b1}, 8'h00);
        for (int i = 0; i < n; i++) begin
            q.push_back(e[15 - 8 * i -: 8]);
            i_tsg_master.rbyte(i == n - 1);
        end
        i_tsg_master.stop();
    endtask : rd
    task automatic cv(input logic [8:0] v);
        @(posedge clk);
        #1 conv = {1'b1, v};
        #4 conv.done = 1'b0;
        #16;
    endtask : cv

    initial begin
        strap = 3'($urandom(5));
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        #120;
        rd(8'h01, 1, 16'h0000);
        rd(8'h02, 2, 16'h4B00);
        rd(8'h03, 2, 16'h5000);
        for (int i = 0; i < 3; i++) begin
            i_tsg_master.start();
            xw({tsg_pkg::ADDR_PREFIX, strap ^ 3'(1 << i), 1'b1}, 8'h01);
            i_tsg_master.stop();
        end
        // spike on the bus clock inside an address byte
        fork
            wr(8'h00, 0, 16'h0000);
            begin
                repeat (205) @(posedge clk);
                #1 gl = 1'b1;
                #32 gl = 1'b0;
            end
        join
        // kept below the limits so no fault counts yet
        repeat (2) begin
            t = 9'($urandom) & 9'h07F;
            cv(t);
            rd(8'h00, 2, {t, 7'h00});
        end
        t2 = 9'($urandom) & 9'h07F;
        fork
            rd(8'h00, 2, {t, 7'h00});
            begin
                repeat (2900) @(posedge clk);
                cv(t2);
            end
        join
        rd(8'h00, 2, {t, 7'h00});
        cv(t2);
        rd(8'h00, 2, {t2, 7'h00});
        for (int f = 0; f < 4; f++) begin
            wr(8'h01, 1, {3'h0, 2'(f), 3'h0, 8'h00});
            repeat (NF[f] - 1) cv(9'h0A1);
            check(9'(al_oe), 9'h000);
            cv(9'h0A1);
            check(9'(al_oe), 9'h001);
            repeat (NF[f]) cv(9'h095);
            check(9'(al_oe), 9'h000);
        end
        // interrupt mode: latched until a read, then polarity flip
        wr(8'h01, 1, 16'h0200);
        cv(9'h0A1);
        check(9'(al_oe), 9'h001);
        rd(8'h00, 2, {9'h0A1, 7'h00});
        check(9'(al_oe), 9'h000);
        wr(8'h01, 1, 16'h0600);
        check(9'(al_oe), 9'h001);
        cv(9'h095);
        check(9'(al_oe), 9'h000);
        // slave left driving a zero with the clock parked low
        i_tsg_master.start();
        xw({tsg_pkg::ADDR_PREFIX, strap, 1'b1}, 8'h00);
        #(2 * TO);
        check(9'(sda_oe), 9'h001);
        #(2 * TO + 240);
        check(9'(sda_oe), 9'h000);
        i_tsg_master.stop();
        wr(8'h01, 1, 16'h1900);
        check(9'(shdn), 9'h001);
        rst_n = 1'b0;
        #1200 rst_n = 1'b1;
        #120;
        check(9'(shdn), 9'h000);
        rd(8'h01, 1, 16'h0000);
        rd(8'h03, 2, 16'h5000);
        check(9'(q.size()), 9'h000);
        end_sim();
    end
endmodule : tb_top

// *** verification/tsg_master.sv ***
// two-wire bus master model facing the slave
`timescale 1ns/10ps
module tsg_master #(
    parameter int Q = 20
) (
    // clock
    input  wire logic  clk_i,
    // bus
    input  wire logic  sda_i,
    output logic       scl_oe_o,
    output logic       sda_oe_o,
    // results seen
    output logic       rx_stb_o,
    output logic [7:0] rx_val_o
);
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        rx_stb_o = 1'b0;
        rx_val_o = 8'h00;
    end
    // quarter bit steps, always just after an edge
    task automatic qw(input int n);
        repeat (n * Q) @(posedge clk_i);
        #1;
    endtask : qw
    task automatic emit(input logic [7:0] v);
        rx_val_o = v;
        rx_stb_o = 1'b1;
        @(posedge clk_i);
        #1 rx_stb_o = 1'b0;
    endtask : emit
    task automatic start();
        sda_oe_o = 1'b1;
        qw(1);
        scl_oe_o = 1'b1;
        qw(1);
    endtask : start
    task automatic stop();
        sda_oe_o = 1'b1;
        qw(1);
        scl_oe_o = 1'b0;
        qw(1);
        sda_oe_o = 1'b0;
        qw(2);
    endtask : stop
    // data only moves while the clock is held low
    task automatic bt(input logic b, output logic s);
        sda_oe_o = !b;
        qw(1);
        scl_oe_o = 1'b0;
        qw(1);
        s = sda_i;
        qw(1);
        scl_oe_o = 1'b1;
        qw(1);
    endtask : bt
    task automatic wbyte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bt(d[i], s);
        bt(1'b1, s);
        emit({7'h00, s});
    endtask : wbyte
    task automatic rbyte(input logic last);
        logic [7:0] d;
        logic s;
        for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
        bt(last, s);
        emit(d);
    endtask : rbyte
endmodule : tsg_master

// *** verification/tsg_top_monitor.sv ***
// concurrent checks on the pins of the sensor bus slave
`timescale 1ns/10ps
module tsg_top_monitor #(
    parameter int TIMEOUT_CYC = 3000
) (
    // clock and resets
    input wire logic               CLK_SYS_I,
    input wire logic               SYS_RST_I,
    input wire logic               RESET_N_I,
    // bus pins
    input wire logic               SCL_I,
    input wire logic               SDA_I,
    input wire logic               SDA_O,
    input wire logic               SDA_OE_O,
    // converter and alarm
    input wire tsg_pkg::tsg_conv_s CONV_I,
    input wire logic               SHUTDOWN_O,
    input wire logic               OVERTEMP_ALARM_OUT_O,
    input wire logic               OVERTEMP_ALARM_OUT_OE_O
);
    int sda_lo_ff;
    int rst_lo_ff;
    int age_ff;
    int scl_age_ff;
    // counters saturate so long idle stretches cannot wrap
    always_ff @(posedge CLK_SYS_I)
        if (SYS_RST_I || SDA_I) sda_lo_ff <= 0;
        else if (sda_lo_ff < 99999) sda_lo_ff <= sda_lo_ff + 1;
    always_ff @(posedge CLK_SYS_I)
        if (SYS_RST_I || RESET_N_I) rst_lo_ff <= 0;
        else if (rst_lo_ff < 999) rst_lo_ff <= rst_lo_ff + 1;
    always_ff @(posedge CLK_SYS_I)
        if (SYS_RST_I || CONV_I.done) age_ff <= 0;
        else if (age_ff < 99) age_ff <= age_ff + 1;
    // config writes and read clears move the alarm while the clock is low
    always_ff @(posedge CLK_SYS_I)
        if (SYS_RST_I || !SCL_I) scl_age_ff <= 0;
        else if (scl_age_ff < 99) scl_age_ff <= scl_age_ff + 1;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (SYS_RST_I);

    property p_alarm_od; OVERTEMP_ALARM_OUT_O == 1'b0; endproperty
    a_alarm_od: assert property (p_alarm_od)
        else $error("alarm pin driven high");
    property p_sda_od; SDA_O == 1'b0; endproperty
    a_sda_od: assert property (p_sda_od)
        else $error("data pin driven high");
    property p_timeout; sda_lo_ff == TIMEOUT_CYC + 40 |-> !SDA_OE_O; endproperty
    a_timeout: assert property (p_timeout)
        else $error("stuck data line not released");
    property p_rst_pin; rst_lo_ff == 260 |-> !SHUTDOWN_O && !SDA_OE_O; endproperty
    a_rst_pin: assert property (p_rst_pin)
        else $error("reset pin did not clear state");
    property p_shdn_fall; $fell(SHUTDOWN_O) |-> rst_lo_ff >= 250; endproperty
    a_shdn_fall: assert property (p_shdn_fall)
        else $error("shutdown cleared without long reset pulse");
    property p_sda_move; $changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I);
    endproperty
    a_sda_move: assert property (p_sda_move)
        else $error("data moved while bus clock high");
    property p_alarm_cause;
        $changed(OVERTEMP_ALARM_OUT_OE_O) |-> age_ff < 6 || scl_age_ff < 40;
    endproperty
    a_alarm_cause: assert property (p_alarm_cause)
        else $error("alarm moved without a conversion");
    property p_rst_vals;
        $fell(SYS_RST_I) |-> !SDA_OE_O && !SHUTDOWN_O && !OVERTEMP_ALARM_OUT_OE_O;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs not at reset values");
endmodule : tsg_top_monitor

bind tsg_top tsg_top_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_tsg_top_monitor (.*);
